// ---- include/conv_vcode_pkg.sv ----
// Package for the converter five and six voltage code register bank.
package conv_vcode_pkg;

    // ========================================================================
    // Register offsets
    localparam logic [7:0] CONV5_NORMAL_OFS = 8'h96;
    localparam logic [7:0] CONV5_SLEEP_OFS  = 8'h97;
    localparam logic [7:0] CONV6_NORMAL_OFS = 8'h98;
    localparam logic [7:0] CONV6_SLEEP_OFS  = 8'h99;

    // ========================================================================
    // Field layout
    localparam int CODE_MSB  = 7;
    localparam int CODE_LSB  = 1;
    localparam int DECAY_BIT = 0;
    localparam int RSVD_BIT  = 0;

    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ========================================================================
    // Factory reset values, one entry per device variant (0 to 3)
    localparam logic [7:0] CONV5_NORMAL_RST [4] = '{8'h70, 8'hE8, 8'h40, 8'hE8};
    localparam logic [7:0] CONV5_SLEEP_RST  [4] = '{8'h70, 8'hE8, 8'h40, 8'hE8};
    localparam logic [7:0] CONV6_NORMAL_RST [4] = '{8'hBE, 8'hDC, 8'h70, 8'h58};
    localparam logic [7:0] CONV6_SLEEP_RST  [4] = '{8'hBE, 8'h8C, 8'h70, 8'h4C};

    // ========================================================================
    // Carriers
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } reg_req_t;

    typedef struct packed {
        logic [6:0] target;
        logic       slewDown;
        logic       passiveDecay;
    } rail_ctrl_t;

endpackage : conv_vcode_pkg

// ---- rtl/converter_voltage_code_regs.sv ----
// Voltage code registers for converter five and converter six.
// Notes on behaviour
// - Converter five normal code, R/W bits 7:1 at 96h, drives its normal target.
// - Converter five sleep code, R/W bits 7:1 at 97h, drives its sleep target.
// - Converter six normal code, R/W bits 7:1 at 98h, drives its normal target.
// - Converter six sleep code, R/W bits 7:1 at 99h, drives its sleep target.
// - Normal bit 0 low: a lowered code makes the converter actively slew down.
// - Normal bit 0 high: a lowered code lets the output decay passively.
// - All four registers reset to factory values chosen per device variant.
`timescale 1ns/100ps
`default_nettype none

module converter_voltage_code_regs #(
    parameter int unsigned VARIANT = 0
) (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire conv_vcode_pkg::reg_req_t   regReq,
    input  wire logic                       conv5SleepMode,
    input  wire logic                       conv6SleepMode,
    output logic [7:0]                      rdData,
    output logic                            rdValid,
    output conv_vcode_pkg::rail_ctrl_t      converterFive,
    output conv_vcode_pkg::rail_ctrl_t      converterSix
);

    // ========================================================================
    // Reset images
    // The variant picks one byte per register. Every field is cut from it
    // here, so that the write, read and rail logic share one definition
    // of what the block comes out of reset with.
    localparam logic [7:0] C5N_RST = conv_vcode_pkg::CONV5_NORMAL_RST[VARIANT];
    localparam logic [7:0] C5S_RST = conv_vcode_pkg::CONV5_SLEEP_RST[VARIANT];
    localparam logic [7:0] C6N_RST = conv_vcode_pkg::CONV6_NORMAL_RST[VARIANT];
    localparam logic [7:0] C6S_RST = conv_vcode_pkg::CONV6_SLEEP_RST[VARIANT];

    localparam int CMSB = conv_vcode_pkg::CODE_MSB;
    localparam int CLSB = conv_vcode_pkg::CODE_LSB;
    localparam int DBIT = conv_vcode_pkg::DECAY_BIT;
    localparam int RBIT = conv_vcode_pkg::RSVD_BIT;

    localparam logic [6:0] C5N_RST_CODE  = C5N_RST[CMSB:CLSB];
    localparam logic [6:0] C5S_RST_CODE  = C5S_RST[CMSB:CLSB];
    localparam logic [6:0] C6N_RST_CODE  = C6N_RST[CMSB:CLSB];
    localparam logic [6:0] C6S_RST_CODE  = C6S_RST[CMSB:CLSB];
    localparam logic       C5N_RST_DECAY = C5N_RST[DBIT];
    localparam logic       C6N_RST_DECAY = C6N_RST[DBIT];
    localparam logic       C5S_RST_RSVD  = C5S_RST[RBIT];
    localparam logic       C6S_RST_RSVD  = C6S_RST[RBIT];

    // ========================================================================
    // Storage
    // Normal registers keep all eight bits, decay choice included. Sleep
    // registers keep only the code, because their reserved bit has no
    // storage behind it and always shows its reset value.
    logic [7:0] conv5Normal_r;
    logic [6:0] conv5SleepCode_r;
    logic [7:0] conv6Normal_r;
    logic [6:0] conv6SleepCode_r;

    // ========================================================================
    // Helper functions
    // Returns the code that the rail should regulate to in its present mode.
    function automatic logic [6:0] pickTarget(
        input logic       sleepMode,
        input logic [7:0] normalReg,
        input logic [6:0] sleepCode
    );
        pickTarget = sleepMode ? sleepCode
                               : normalReg[conv_vcode_pkg::CODE_MSB:
                                           conv_vcode_pkg::CODE_LSB];
    endfunction : pickTarget

    // Produces the next control state of one rail from its new target.
    // A drop in target raises slewDown only when active slewing is chosen;
    // a rise, or a switch to passive decay, lowers it. An unchanged target
    // keeps the previous choice so the converter finishes its transition.
    function automatic conv_vcode_pkg::rail_ctrl_t nextRail(
        input conv_vcode_pkg::rail_ctrl_t cur,
        input logic [6:0]                 tgt,
        input logic                       decaySel
    );
        conv_vcode_pkg::rail_ctrl_t n;
        n = cur;
        n.target = tgt;
        n.passiveDecay = decaySel;
        if (tgt < cur.target) begin
            n.slewDown = ~decaySel;
        end else if (tgt > cur.target || decaySel) begin
            n.slewDown = 1'h0;
        end
        nextRail = n;
    endfunction : nextRail

    // True when the request on this cycle writes the register at ofs.
    // Only an exact offset match lands; every other offset, mapped or
    // not, leaves the register untouched.
    function automatic logic hitWrite(
        input conv_vcode_pkg::reg_req_t req,
        input logic [7:0]               ofs
    );
        hitWrite = req.wrEn && (req.addr == ofs);
    endfunction : hitWrite

    // Assembles the byte that a sleep register reads back: the stored
    // code above the reserved bit. Keeping this in one place stops the
    // two sleep registers from drifting apart in layout.
    function automatic logic [7:0] sleepImage(
        input logic [6:0] code,
        input logic       rsvd
    );
        sleepImage = {code, rsvd};
    endfunction : sleepImage

    // ========================================================================
    // Register writes
    // A write lands on the edge that takes it, so a read taken on the
    // following edge already returns the new byte.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            conv5Normal_r <= C5N_RST;
        end else if (hitWrite(regReq, conv_vcode_pkg::CONV5_NORMAL_OFS)) begin
            conv5Normal_r <= regReq.wrData;
        end
    end

    // Bit 0 of the write data is dropped: the reserved bit cannot be set.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            conv5SleepCode_r <= C5S_RST_CODE;
        end else if (hitWrite(regReq, conv_vcode_pkg::CONV5_SLEEP_OFS)) begin
            conv5SleepCode_r <= regReq.wrData[CMSB:CLSB];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            conv6Normal_r <= C6N_RST;
        end else if (hitWrite(regReq, conv_vcode_pkg::CONV6_NORMAL_OFS)) begin
            conv6Normal_r <= regReq.wrData;
        end
    end

    // Bit 0 of the write data is dropped: the reserved bit cannot be set.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            conv6SleepCode_r <= C6S_RST_CODE;
        end else if (hitWrite(regReq, conv_vcode_pkg::CONV6_SLEEP_OFS)) begin
            conv6SleepCode_r <= regReq.wrData[CMSB:CLSB];
        end
    end

    // ========================================================================
    // Register reads
    // rdValid marks the cycle after each read strobe and nothing else.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdValid <= 1'h0;
        end else begin
            rdValid <= regReq.rdEn;
        end
    end

    // rdData samples the storage before a write on the same edge lands, so
    // a read and a write taken together return the old byte. It then holds
    // until the next read strobe.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdData <= conv_vcode_pkg::UNMAPPED_READ;
        end else if (regReq.rdEn) begin
            case (regReq.addr)
                conv_vcode_pkg::CONV5_NORMAL_OFS: begin
                    rdData <= conv5Normal_r;
                end
                conv_vcode_pkg::CONV5_SLEEP_OFS: begin
                    rdData <= sleepImage(conv5SleepCode_r, C5S_RST_RSVD);
                end
                conv_vcode_pkg::CONV6_NORMAL_OFS: begin
                    rdData <= conv6Normal_r;
                end
                conv_vcode_pkg::CONV6_SLEEP_OFS: begin
                    rdData <= sleepImage(conv6SleepCode_r, C6S_RST_RSVD);
                end
                // Unmapped offsets read as zero; nothing signals the miss.
                default: begin
                    rdData <= conv_vcode_pkg::UNMAPPED_READ;
                end
            endcase
        end
    end

    // ========================================================================
    // Rail control
    // The target follows its register or mode input one cycle later, and
    // slewDown is a held level rather than a pulse.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            converterFive <= '{target:       C5N_RST_CODE,
                               slewDown:     1'h0,
                               passiveDecay: C5N_RST_DECAY};
        end else begin
            converterFive <= nextRail(converterFive,
                pickTarget(conv5SleepMode, conv5Normal_r, conv5SleepCode_r),
                conv5Normal_r[DBIT]);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            converterSix <= '{target:       C6N_RST_CODE,
                              slewDown:     1'h0,
                              passiveDecay: C6N_RST_DECAY};
        end else begin
            converterSix <= nextRail(converterSix,
                pickTarget(conv6SleepMode, conv6Normal_r, conv6SleepCode_r),
                conv6Normal_r[DBIT]);
        end
    end

endmodule : converter_voltage_code_regs
`default_nettype wire

// ---- verification/conv_vcode_sva.sv ----
// Assertions for the converter voltage code registers.
`timescale 1ns/100ps
`default_nettype none
module conv_vcode_sva #(parameter int unsigned VARIANT = 0) (
    input wire logic                       mclk,
    input wire logic                       rst,
    input wire conv_vcode_pkg::reg_req_t   regReq,
    input wire logic                       conv5SleepMode,
    input wire logic                       conv6SleepMode,
    input wire logic [7:0]                 rdData,
    input wire logic                       rdValid,
    input wire conv_vcode_pkg::rail_ctrl_t converterFive,
    input wire conv_vcode_pkg::rail_ctrl_t converterSix
);
    // ====
    // Checks
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic h96 = regReq.wrEn && regReq.addr == 8'h96;
    wire logic h97 = regReq.wrEn && regReq.addr == 8'h97;
    wire logic h98 = regReq.wrEn && regReq.addr == 8'h98;
    wire logic h99 = regReq.wrEn && regReq.addr == 8'h99;
    property p_tgt(h, m, t);
        h ##1 m && !h |=> t == $past(regReq.wrData[7:1], 2);
    endproperty
    a_c5_normal: assert property (
        p_tgt(h96, !conv5SleepMode, converterFive.target)) else $error("c5n");
    a_c5_sleep: assert property (
        p_tgt(h97, conv5SleepMode, converterFive.target)) else $error("c5s");
    a_c6_normal: assert property (
        p_tgt(h98, !conv6SleepMode, converterSix.target)) else $error("c6n");
    a_c6_sleep: assert property (
        p_tgt(h99, conv6SleepMode, converterSix.target)) else $error("c6s");
    a_slew_down: assert property (
        converterFive.target < $past(converterFive.target) &&
        !converterFive.passiveDecay |-> converterFive.slewDown) else $error("sd");
    a_decay_hold: assert property (
        converterFive.target < $past(converterFive.target) &&
        converterFive.passiveDecay |-> !converterFive.slewDown) else $error("pd");
    a_reset_load: assert property (
        $fell(rst) |-> converterSix.target ==
        conv_vcode_pkg::CONV6_NORMAL_RST[VARIANT][7:1]) else $error("rv");
    a_rsvd_read: assert property (
        regReq.rdEn && regReq.addr == 8'h97 |=> rdValid &&
        rdData[0] == conv_vcode_pkg::CONV5_SLEEP_RST[VARIANT][0]) else $error("rb");
    c_sleep: cover property (h97 ##1 conv5SleepMode);
    c_slew: cover property ($rose(converterFive.slewDown));
    c_read: cover property (rdValid);
endmodule : conv_vcode_sva
bind converter_voltage_code_regs conv_vcode_sva #(.VARIANT(VARIANT)) chk (
    .mclk(mclk), .rst(rst), .regReq(regReq), .conv5SleepMode(conv5SleepMode),
    .conv6SleepMode(conv6SleepMode), .rdData(rdData), .rdValid(rdValid),
    .converterFive(converterFive), .converterSix(converterSix));
`default_nettype wire

// ---- verification/reg_host.sv ----
// Host model that issues single register reads and writes.
`timescale 1ns/100ps
`default_nettype none
module reg_host (
    input wire logic                      mclk,
    input wire logic [7:0]                rdData,
    input wire logic                      rdValid,
    output var conv_vcode_pkg::reg_req_t regReq
);
    // ====
    // One strobe per access; read data is taken at the negedge that ends the pulse, just after the strobe drops.
    initial regReq = '0;
    task automatic xfer(input logic wr, input logic [7:0] ad, dat,
                        output logic [7:0] q);
        @(negedge mclk);
        regReq = {wr, !wr, ad, dat};
        @(negedge mclk);
        regReq = '0;
        q = rdValid ? rdData : 8'hXX;
    endtask : xfer
endmodule : reg_host
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking testbench for the converter voltage code registers.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int unsigned V = 1;
    logic mclk, rst, conv5SleepMode, conv6SleepMode, rdValid;
    logic [7:0] rdData, q;
    conv_vcode_pkg::reg_req_t   regReq;
    conv_vcode_pkg::rail_ctrl_t five, six;
    int failures = 0, tests_run = 0;
    logic [7:0] rstTab [4] = '{conv_vcode_pkg::CONV5_NORMAL_RST[V],
        conv_vcode_pkg::CONV5_SLEEP_RST[V], conv_vcode_pkg::CONV6_NORMAL_RST[V],
        conv_vcode_pkg::CONV6_SLEEP_RST[V]};
    converter_voltage_code_regs #(.VARIANT(V)) dut (.mclk(mclk), .rst(rst),
        .regReq(regReq), .conv5SleepMode(conv5SleepMode),
        .conv6SleepMode(conv6SleepMode), .rdData(rdData), .rdValid(rdValid),
        .converterFive(five), .converterSix(six));
    reg_host host (.mclk(mclk), .rdData(rdData), .rdValid(rdValid),
        .regReq(regReq));
    // ====
    // Scenarios
    task automatic chk(input string n, input logic [7:0] e, s);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic t_reset;
        for (int i = 0; i < 4; i++) begin
            host.xfer(1'h0, 8'h96 + 8'(i), 8'h00, q);
            chk("reset value", rstTab[i], q);
        end
        chk("c6 reset target", {1'h0, rstTab[2][7:1]}, {1'h0, six.target});
    endtask : t_reset
    task automatic t_rw;
        for (int i = 0; i < 5; i++) begin
            host.xfer(1'h1, 8'h96 + 8'(i), 8'hFF, q);
            host.xfer(1'h0, 8'h96 + 8'(i), 8'h00, q);
            chk("read back", i % 2 ? {7'h7F, rstTab[i][0]} : i == 4 ?
                conv_vcode_pkg::UNMAPPED_READ : 8'hFF, q);
        end
    endtask : t_rw
    task automatic t_mode;
        host.xfer(1'h1, 8'h96, 8'h50, q);
        host.xfer(1'h1, 8'h97, 8'h20, q);
        host.xfer(1'h1, 8'h98, 8'h60, q);
        host.xfer(1'h1, 8'h99, 8'h30, q);
        @(negedge mclk);
        chk("c5 normal", 8'h28, {1'h0, five.target});
        chk("c6 normal", 8'h30, {1'h0, six.target});
        conv5SleepMode = 1'h1;
        conv6SleepMode = 1'h1;
        @(negedge mclk);
        chk("c5 sleep", 8'h10, {1'h0, five.target});
        chk("c6 sleep", 8'h18, {1'h0, six.target});
        host.xfer(1'h1, 8'h97, 8'h40, q);
        host.xfer(1'h1, 8'h99, 8'h44, q);
        @(negedge mclk);
        chk("c5 sleep rewrite", 8'h20, {1'h0, five.target});
        chk("c6 sleep rewrite", 8'h22, {1'h0, six.target});
        conv5SleepMode = 1'h0;
        conv6SleepMode = 1'h0;
    endtask : t_mode
    task automatic t_slew;
        host.xfer(1'h1, 8'h96, 8'hF0, q);
        host.xfer(1'h1, 8'h96, 8'h40, q);
        @(negedge mclk);
        chk("slew", 8'h01, {6'h00, five.passiveDecay, five.slewDown});
        host.xfer(1'h1, 8'h96, 8'hF1, q);
        host.xfer(1'h1, 8'h96, 8'h41, q);
        @(negedge mclk);
        chk("decay", 8'h02, {6'h00, five.passiveDecay, five.slewDown});
    endtask : t_slew
    task automatic finish_test;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        rst = 1'h1;
        conv5SleepMode = 1'h0;
        conv6SleepMode = 1'h0;
        repeat (8) @(negedge mclk);
        rst = 1'h0;
        t_reset;
        t_rw;
        t_mode;
        t_slew;
        finish_test;
    end
    initial begin
        #20000;
        failures++;
        finish_test;
    end
endmodule : testbench
`default_nettype wire
